// ### shared/lrt_pkg.sv
package lrt_pkg;

  // register indices on the plain register port
  localparam logic [3:0] LRT_ADDR_SIZE = 4'h0;
  localparam logic [3:0] LRT_ADDR_LINE = 4'h1;
  localparam logic [3:0] LRT_ADDR_FRAME = 4'h2;
  localparam logic [3:0] LRT_ADDR_POL = 4'h3;
  localparam logic [3:0] LRT_ADDR_CLKDIV = 4'h4;
  localparam logic [3:0] LRT_ADDR_STATUS = 4'h5;

  // field positions: two 12-bit fields in size, three 10-bit in sync regs
  localparam int LRT_SZ_W = 12;
  localparam int LRT_PAR_W = 10;
  localparam int LRT_F0_LSB = 0;
  localparam int LRT_F1_LSB = 10;
  localparam int LRT_F2_LSB = 20;
  localparam int LRT_SZ_Y_LSB = 16;
  localparam int LRT_POL_LINE_BIT = 0;
  localparam int LRT_POL_FRAME_BIT = 1;
  localparam int LRT_CK_DIV_LSB = 0;
  localparam int LRT_CK_INV_BIT = 8;
  localparam int LRT_CK_PH_BIT = 9;
  localparam int LRT_CK_EN_BIT = 10;

  // reset values
  localparam logic [31:0] LRT_RST_SIZE = 32'h0010_0010;
  localparam logic [31:0] LRT_RST_LINE = 32'h0010_0401;
  localparam logic [31:0] LRT_RST_FRAME = 32'h0010_0401;
  localparam logic [31:0] LRT_RST_POL = 32'h0000_0000;
  localparam logic [31:0] LRT_RST_CLKDIV = 32'h0000_0003;

  // timing: least pixel period and least platform-to-pixel ratio
  localparam int LRT_SYS_PERIOD_PS = 4000;
  localparam int LRT_PIX_MIN_PS = 7500;
  localparam int LRT_PIX_MIN_RATIO = 3;
  localparam int LRT_DIV_MIN_PERIOD =
    (LRT_PIX_MIN_PS + LRT_SYS_PERIOD_PS - 1) / LRT_SYS_PERIOD_PS;
  localparam int LRT_DIV_MIN = (LRT_DIV_MIN_PERIOD > LRT_PIX_MIN_RATIO) ?
    LRT_DIV_MIN_PERIOD : LRT_PIX_MIN_RATIO;

  typedef enum logic [3:0] {
    LRT_SEG_PULSE = 4'h1,
    LRT_SEG_BACK = 4'h2,
    LRT_SEG_ACTIVE = 4'h4,
    LRT_SEG_FRONT = 4'h8
  } lrt_seg_t;

  typedef struct packed {
    logic [LRT_PAR_W-1:0] front;
    logic [LRT_PAR_W-1:0] back;
    logic [LRT_PAR_W-1:0] pulse;
  } lrt_sync_t;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic pixel_valid;
  } lrt_ctl_t;

endpackage : lrt_pkg

// ### rtl/lrt_timing_gen.sv
`timescale 1ns/1ns
`default_nettype none
module lrt_timing_gen
  import lrt_pkg::*;
#(
  parameter int PIX_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [PIX_W-1:0] pixel_in,
  output logic pixel_take,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic pixel_valid_out,
  output logic panel_clock_pin,
  output logic [PIX_W-1:0] pixel_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [LRT_PAR_W-1:0] fld(input logic [31:0] r,
                                               input int lsb);
    fld = r[lsb +: LRT_PAR_W];
  endfunction : fld

  // check a segment counter; returns 1 when its last count is reached
  function automatic logic seg_last(input lrt_seg_t s,
                                    input logic [LRT_SZ_W-1:0] cnt,
                                    input lrt_sync_t p,
                                    input logic [LRT_SZ_W-1:0] act);
    logic [LRT_SZ_W-1:0] len;
    len = '0;
    unique case (s)
      LRT_SEG_PULSE: len = LRT_SZ_W'(p.pulse);
      LRT_SEG_BACK: len = LRT_SZ_W'(p.back);
      LRT_SEG_ACTIVE: len = act;
      LRT_SEG_FRONT: len = LRT_SZ_W'(p.front);
      default: len = '0;
    endcase
    seg_last = (cnt + 12'h001 >= len);
  endfunction : seg_last

  function automatic lrt_seg_t seg_next(input lrt_seg_t s);
    unique case (s)
      LRT_SEG_PULSE: seg_next = LRT_SEG_BACK;
      LRT_SEG_BACK: seg_next = LRT_SEG_ACTIVE;
      LRT_SEG_ACTIVE: seg_next = LRT_SEG_FRONT;
      default: seg_next = LRT_SEG_PULSE;
    endcase
  endfunction : seg_next

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] size_q, line_q, frame_q, pol_q, ckdiv_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      size_q <= LRT_RST_SIZE;
      line_q <= LRT_RST_LINE;
      frame_q <= LRT_RST_FRAME;
      pol_q <= LRT_RST_POL;
      ckdiv_q <= LRT_RST_CLKDIV;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == LRT_ADDR_SIZE) size_q <= reg_wdata;
      if (reg_addr == LRT_ADDR_LINE) line_q <= reg_wdata;
      if (reg_addr == LRT_ADDR_FRAME) frame_q <= reg_wdata;
      if (reg_addr == LRT_ADDR_POL) pol_q <= reg_wdata & 32'h0000_0003;
      if (reg_addr == LRT_ADDR_CLKDIV) ckdiv_q <= reg_wdata & 32'h0000_07FF;
    end
  end

  wire lrt_sync_t hpar = '{front: fld(line_q, LRT_F2_LSB),
                           back: fld(line_q, LRT_F1_LSB),
                           pulse: fld(line_q, LRT_F0_LSB)};
  wire lrt_sync_t vpar = '{front: fld(frame_q, LRT_F2_LSB),
                           back: fld(frame_q, LRT_F1_LSB),
                           pulse: fld(frame_q, LRT_F0_LSB)};
  wire logic [LRT_SZ_W-1:0] act_x = size_q[LRT_SZ_W-1:0];
  wire logic [LRT_SZ_W-1:0] act_y = size_q[LRT_SZ_Y_LSB +: LRT_SZ_W];

  // divider below the legal floor is clamped rather than refused
  wire logic [7:0] div_raw = ckdiv_q[LRT_CK_DIV_LSB +: 8];
  wire logic [7:0] div_eff = (div_raw < 8'(LRT_DIV_MIN)) ?
                             8'(LRT_DIV_MIN) : div_raw;
  wire logic ck_inv = ckdiv_q[LRT_CK_INV_BIT];
  wire logic ck_phase = ckdiv_q[LRT_CK_PH_BIT];
  wire logic run = ckdiv_q[LRT_CK_EN_BIT] == 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock made from sys_clk by a divider; tick marks its rising edge
  logic [7:0] div_q;
  logic pix_clk_q;
  wire logic tick = run && (div_q == 8'h00);
  wire logic half = run && (div_q == (div_eff >> 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      pix_clk_q <= 1'b0;
    end else if (clk_en) begin
      div_q <= (div_q + 8'h01 >= div_eff) ? 8'h00 : div_q + 8'h01;
      if (tick) pix_clk_q <= 1'b1;
      else if (half) pix_clk_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  lrt_seg_t hseg_q, vseg_q;
  logic [LRT_SZ_W-1:0] hcnt_q, vcnt_q;
  wire logic h_last = seg_last(hseg_q, hcnt_q, hpar, act_x);
  wire logic v_last = seg_last(vseg_q, vcnt_q, vpar, act_y);
  wire logic line_end = h_last && (hseg_q == LRT_SEG_FRONT);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hseg_q <= LRT_SEG_PULSE;
      vseg_q <= LRT_SEG_PULSE;
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (clk_en && tick) begin
      hcnt_q <= h_last ? '0 : hcnt_q + 12'h001;
      if (h_last) hseg_q <= seg_next(hseg_q);
      if (line_end) begin
        vcnt_q <= v_last ? '0 : vcnt_q + 12'h001;
        if (v_last) vseg_q <= seg_next(vseg_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire logic in_active = (hseg_q == LRT_SEG_ACTIVE) &&
                         (vseg_q == LRT_SEG_ACTIVE);
  wire lrt_ctl_t ctl_d = '{
    line_sync: (hseg_q == LRT_SEG_PULSE) ^ pol_q[LRT_POL_LINE_BIT],
    frame_sync: (vseg_q == LRT_SEG_PULSE) ^ pol_q[LRT_POL_FRAME_BIT],
    pixel_valid: in_active};

  // sync, valid and data outputs follow the counters one pixel edge later, all on the same tick; pixel_take is a one-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      pixel_valid_out <= 1'b0;
      pixel_data_out <= '0;
      pixel_take <= 1'b0;
    end else if (clk_en) begin
      pixel_take <= tick && in_active;
      if (tick) begin
        line_sync_out <= ctl_d.line_sync;
        frame_sync_out <= ctl_d.frame_sync;
        pixel_valid_out <= ctl_d.pixel_valid;
        pixel_data_out <= in_active ? pixel_in : '0;
      end
    end
  end

  // phase delay shifts the panel clock by one platform cycle
  logic pix_dly_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pix_dly_q <= 1'b0;
      panel_clock_pin <= 1'b0;
    end else if (clk_en) begin
      pix_dly_q <= pix_clk_q;
      panel_clock_pin <= (ck_phase ? pix_dly_q : pix_clk_q) ^ ck_inv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire logic [31:0] status = {6'h00, vseg_q, vcnt_q, hseg_q, 6'h00};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      LRT_ADDR_SIZE: rd_mux = size_q;
      LRT_ADDR_LINE: rd_mux = line_q;
      LRT_ADDR_FRAME: rd_mux = frame_q;
      LRT_ADDR_POL: rd_mux = pol_q;
      LRT_ADDR_CLKDIV: rd_mux = ckdiv_q;
      LRT_ADDR_STATUS: rd_mux = status;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (clk_en) reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_div_floor;
    div_eff >= 8'(LRT_DIV_MIN);
  endproperty
  a_div_floor: assert property (p_div_floor)
    else $error("pixel divider below legal floor");

  property p_tick_spacing;
    clk_en && tick ##1 clk_en [*2] |-> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("pixel ticks closer than three platform cycles");

  property p_hseg_order;
    clk_en && tick && h_last && hseg_q == LRT_SEG_BACK |=>
      hseg_q == LRT_SEG_ACTIVE && hcnt_q == '0;
  endproperty
  a_hseg_order: assert property (p_hseg_order)
    else $error("line segment order broken");

  property p_vstep;
    clk_en && tick && !line_end |=> $stable(vcnt_q) && $stable(vseg_q);
  endproperty
  a_vstep: assert property (p_vstep)
    else $error("frame counter moved inside a line");

  property p_out_on_tick;
    clk_en && !tick |=> $stable(pixel_valid_out) && $stable(line_sync_out);
  endproperty
  a_out_on_tick: assert property (p_out_on_tick)
    else $error("output changed off the pixel edge");

  property p_line_pol;
    clk_en && tick |=> line_sync_out ==
      ($past(hseg_q == LRT_SEG_PULSE) ^ $past(pol_q[LRT_POL_LINE_BIT]));
  endproperty
  a_line_pol: assert property (p_line_pol)
    else $error("line sync polarity wrong");

  property p_valid_high;
    clk_en && tick && in_active |=> pixel_valid_out;
  endproperty
  a_valid_high: assert property (p_valid_high)
    else $error("pixel valid not high in active area");

  property p_valid_area;
    pixel_valid_out |-> $past(in_active, 1) || $past(pixel_valid_out, 1);
  endproperty
  a_valid_area: assert property (p_valid_area)
    else $error("pixel valid outside active area");

  property p_clk_follow;
    clk_en && $past(clk_en) && !ck_inv && !ck_phase && $stable(ckdiv_q) |=>
      panel_clock_pin == $past(pix_clk_q);
  endproperty
  a_clk_follow: assert property (p_clk_follow)
    else $error("panel clock not following pixel clock");

  // second group: frame polarity, idle levels, segment wraps, clock options
  property p_frame_pol;
    clk_en && tick |=> frame_sync_out ==
      ($past(vseg_q == LRT_SEG_PULSE) ^ $past(pol_q[LRT_POL_FRAME_BIT]));
  endproperty
  a_frame_pol: assert property (p_frame_pol)
    else $error("frame sync polarity wrong");

  property p_valid_low;
    clk_en && tick && !in_active |=> !pixel_valid_out;
  endproperty
  a_valid_low: assert property (p_valid_low)
    else $error("pixel valid high outside active area");

  // data is blanked so a panel that ignores valid still sees black
  property p_data_idle;
    !pixel_valid_out |-> pixel_data_out == '0;
  endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("pixel data not blank outside active area");

  // ticks are at least three platform cycles apart, so a take never repeats
  property p_take_pulse;
    clk_en && pixel_take |=> !pixel_take;
  endproperty
  a_take_pulse: assert property (p_take_pulse)
    else $error("pixel take longer than one cycle");

  property p_line_wrap;
    clk_en && tick && line_end |=>
      hseg_q == LRT_SEG_PULSE && hcnt_q == '0;
  endproperty
  a_line_wrap: assert property (p_line_wrap)
    else $error("line did not restart with its sync pulse");

  property p_vseg_order;
    clk_en && tick && line_end && v_last && vseg_q == LRT_SEG_BACK |=>
      vseg_q == LRT_SEG_ACTIVE && vcnt_q == '0;
  endproperty
  a_vseg_order: assert property (p_vseg_order)
    else $error("frame segment order broken");

  property p_frame_wrap;
    clk_en && tick && line_end && v_last && vseg_q == LRT_SEG_FRONT |=>
      vseg_q == LRT_SEG_PULSE && vcnt_q == '0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("frame did not restart with its sync pulse");

  property p_rdata_idle;
    clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_pix_rise;
    clk_en && tick |=> pix_clk_q;
  endproperty
  a_pix_rise: assert property (p_pix_rise)
    else $error("pixel clock not high after its rising tick");

  property p_clk_invert;
    clk_en && ck_inv && !ck_phase |=>
      panel_clock_pin == !$past(pix_clk_q);
  endproperty
  a_clk_invert: assert property (p_clk_invert)
    else $error("panel clock not inverted");

  // phase delay trades one platform cycle of skew for extra hold margin
  property p_phase_delay;
    clk_en && ck_phase && !ck_inv |=>
      panel_clock_pin == $past(pix_dly_q);
  endproperty
  a_phase_delay: assert property (p_phase_delay)
    else $error("panel clock not delayed");

  c_line_end: cover property (clk_en && tick && line_end);
  c_frame_wrap: cover property (clk_en && tick && line_end && v_last &&
                                vseg_q == LRT_SEG_FRONT);
  c_active_px: cover property (pixel_valid_out && pixel_take);
  c_inverted: cover property (pol_q[LRT_POL_LINE_BIT] && !line_sync_out);
  c_phase: cover property (clk_en && tick && ck_phase);

endmodule : lrt_timing_gen
`default_nettype wire

// ### tb/lrt_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module lrt_panel_model (
  input wire logic sys_clk,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic valid,
  input wire logic pclk,
  input wire logic [1:0] pol,
  output logic line_rpt = 1'b0,
  output logic frame_rpt = 1'b0,
  output var int hs_w,
  output var int per,
  output var int pck,
  output var int vsw,
  output var int nlines,
  output var int de_cyc
);
  // the panel is told the polarity, as a real panel is strapped to it
  wire ls = line_sync ^ pol[0];
  wire fs = frame_sync ^ pol[1];
  logic ls_q = 1'b0, fs_q = 1'b0, pc_q = 1'b0;
  int hc = 0, lc = 0, pc = 0, vc = 0, nl = 0, dc = 0;
  always @(posedge sys_clk) begin
    line_rpt <= 1'b0;
    frame_rpt <= 1'b0;
    ls_q <= ls;
    fs_q <= fs;
    pc_q <= pclk;
    lc <= lc + 1;
    pc <= pc + 1;
    if (valid) dc <= dc + 1;
    if (ls) hc <= ls_q ? hc + 1 : 1;
    if (pclk && !pc_q) begin
      pck <= pc;
      pc <= 1;
    end
    // each report describes the line or frame that just ended
    if (ls && !ls_q) begin
      line_rpt <= 1'b1;
      hs_w <= hc;
      per <= lc;
      lc <= 1;
      nl <= nl + 1;
      if (fs) vc <= vc + 1;
    end
    if (fs && !fs_q) begin
      frame_rpt <= 1'b1;
      vsw <= vc;
      nlines <= nl;
      de_cyc <= dc;
      vc <= 1;
      nl <= 1;
      dc <= 0;
    end
  end
endmodule : lrt_panel_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lrt_pkg::*;
  logic sys_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, xs = 32'hB53E;
  logic [23:0] pixel_in = 24'h0, pixel_data_out;
  logic pixel_take, line_sync_out, frame_sync_out, pixel_valid_out;
  logic panel_clock_pin, line_rpt, frame_rpt, rd_pend = 0;
  logic b0, b1, c0, c1;
  logic [1:0] pol = 2'h0;
  logic [2:0] frz;
  int hs_w, per, pck, vsw, nlines, de_cyc, err_count = 0, cmp_count = 0;
  logic [31:0] rd_q[$];
  int ln_q[$], fr_q[$];

  lrt_timing_gen lrt_timing_gen_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pixel_in(pixel_in), .pixel_take(pixel_take),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
    .pixel_valid_out(pixel_valid_out), .panel_clock_pin(panel_clock_pin),
    .pixel_data_out(pixel_data_out));
  lrt_panel_model lrt_panel_model_inst (.sys_clk(sys_clk),
    .line_sync(line_sync_out), .frame_sync(frame_sync_out),
    .valid(pixel_valid_out), .pclk(panel_clock_pin), .pol(pol),
    .line_rpt(line_rpt), .frame_rpt(frame_rpt), .hs_w(hs_w), .per(per),
    .pck(pck), .vsw(vsw), .nlines(nlines), .de_cyc(de_cyc));

  initial forever #2 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xsh(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xsh

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // w high writes d; w low reads and notes d as the expected word
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) rd_q.push_back(d);
    @(posedge sys_clk);
  endtask : bus

  task idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : idle

  task pin_take(output logic p0, output logic p1);
    @(negedge sys_clk);
    for (int k = 0; k < 200 && !pixel_take; k++) @(negedge sys_clk);
    p0 = panel_clock_pin;
    @(negedge sys_clk);
    p1 = panel_clock_pin;
  endtask : pin_take

  // 5x3 active area; de is the divider after clamping
  task cfg(input logic [7:0] dv, input logic [1:0] p,
    input logic [9:0] fp, input int de);
    int fe;
    fe = (fp == 0) ? 1 : int'(fp);
    bus(1, LRT_ADDR_SIZE, 32'h0003_0005);
    bus(1, LRT_ADDR_LINE, {2'h0, fp, 10'h003, 10'h002});
    bus(1, LRT_ADDR_FRAME, 32'h0010_0802);
    bus(1, LRT_ADDR_POL, {30'h0, p});
    bus(1, LRT_ADDR_CLKDIV, {24'h0, dv});
    pol <= p;
    idle;
    repeat (3) @(posedge frame_rpt);
    repeat (3) ln_q = {ln_q, 2 * de, (10 + fe) * de, de};
    fr_q = {2, 8, 15 * de};
    for (int k = 0; k < 3000 && ln_q.size() + fr_q.size() > 0; k++)
      @(negedge sys_clk);
    chk(ln_q.size() + fr_q.size(), 0);
  endtask : cfg
////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rd_pend && rd_q.size() > 0) chk(reg_rdata, rd_q.pop_front());
    rd_pend <= reg_rd;
    if (line_rpt && ln_q.size() > 2) begin
      chk(hs_w, ln_q.pop_front());
      chk(per, ln_q.pop_front());
      chk(pck, ln_q.pop_front());
    end
    if (frame_rpt && fr_q.size() > 2) begin
      chk(vsw, fr_q.pop_front());
      chk(nlines, fr_q.pop_front());
      chk(de_cyc, fr_q.pop_front());
    end
    if (pixel_take) begin
      chk(pixel_data_out, pixel_in);
      chk({line_sync_out, frame_sync_out, pixel_valid_out},
        {pol[0], pol[1], 1'b1});
      xs <= xsh(xs);
      pixel_in <= xs[23:0];
    end
    if (!pixel_valid_out) chk(pixel_data_out, 0);
  end

  initial begin
    #160000;
    err_count++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(0, LRT_ADDR_SIZE, LRT_RST_SIZE);
    bus(0, LRT_ADDR_LINE, LRT_RST_LINE);
    bus(0, LRT_ADDR_FRAME, LRT_RST_FRAME);
    bus(0, LRT_ADDR_POL, LRT_RST_POL);
    bus(0, LRT_ADDR_CLKDIV, LRT_RST_CLKDIV);
    bus(1, 4'hE, 32'hFFFF_FFFF);
    bus(0, 4'hE, 32'h0);
    bus(1, LRT_ADDR_POL, 32'hFFFF_FFFF);
    bus(0, LRT_ADDR_POL, 32'h3);
    bus(1, LRT_ADDR_CLKDIV, 32'hFFFF_FFFF);
    bus(0, LRT_ADDR_CLKDIV, 32'h7FF);
    cfg(8'h01, 2'h0, 10'h004, 3);
    cfg(8'h04, 2'h3, 10'h000, 4);
    pin_take(b0, b1);
    bus(1, LRT_ADDR_CLKDIV, 32'h104);
    idle;
    pin_take(c0, c1);
    chk(c0 ^ b0, 32'h1);
    bus(1, LRT_ADDR_CLKDIV, 32'h204);
    idle;
    pin_take(c0, c1);
    chk(c1, b0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    @(negedge sys_clk);
    frz = {line_sync_out, frame_sync_out, pixel_valid_out};
    repeat (8) @(negedge sys_clk);
    chk({line_sync_out, frame_sync_out, pixel_valid_out}, frz);
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
